/* verilog/ppb_receiver.sv */
// device end: receives and unpacks the boot stream from the pins
`timescale 1ns/1ns
`default_nettype none
module ppb_receiver
    import ppb_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // link pins
    ppb_link_if.device_end link,
    // load results
    output logic wr_valid_out,
    output logic [31:0] wr_addr_out,
    output logic [15:0] wr_data_out,
    output logic [31:0] entry_point_out,
    output logic wide_mode_out,
    output logic done_out,
    output logic error_out
);
    // ************************************************
    // states
    // ************************************************
    typedef enum logic [1:0]
    {
        PPB_HS_READY = 2'b00,
        PPB_HS_RELEASE = 2'b01,
        PPB_HS_IDLE = 2'b10
    } ppb_hs_type;
    typedef enum logic [3:0]
    {
        PPB_ST_KEY = 4'b0000,
        PPB_ST_KEY_HI = 4'b0001,
        PPB_ST_RSV = 4'b0010,
        PPB_ST_PC_HI = 4'b0011,
        PPB_ST_PC_LO = 4'b0100,
        PPB_ST_SIZE = 4'b0101,
        PPB_ST_ADR_HI = 4'b0110,
        PPB_ST_ADR_LO = 4'b0111,
        PPB_ST_DATA = 4'b1000,
        PPB_ST_DONE = 4'b1001,
        PPB_ST_ERR = 4'b1010
    } ppb_st_type;

    // ************************************************
    // pin synchronisers
    // ************************************************
    // two flops on strobe and data; host has no relation to clk_in
    logic [1:0] strobe_sync_reg;
    logic [15:0] data_s1_reg;
    logic [15:0] data_s2_reg;
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            strobe_sync_reg <= PPB_SYNC_RST;
            data_s1_reg <= PPB_ZERO16;
            data_s2_reg <= PPB_ZERO16;
        end
        else
        begin
            strobe_sync_reg <= {strobe_sync_reg[0], link.host_strobe_line_n};
            data_s1_reg <= link.data_pins;
            data_s2_reg <= data_s1_reg;
        end
    end
    wire strobe_low = ~strobe_sync_reg[1];

    // ************************************************
    // handshake
    // ************************************************
    ppb_hs_type hs_reg, hs_next;
    logic ready_n_reg;
    logic byte_half_reg;
    logic [7:0] low_byte_reg;
    ppb_st_type st_reg, st_next;
    wire active = (st_reg != PPB_ST_DONE) && (st_reg != PPB_ST_ERR);
    // data two-flopped too, and host set it before strobe, so it is settled
    // sample on strobe low
    wire take = (hs_reg == PPB_HS_READY) && strobe_low;
    // low pins only in byte mode
    wire [7:0] pin_byte = data_s2_reg[7:0];
    wire narrow = ~wide_mode_out;
    wire [15:0] pair_word = {pin_byte, low_byte_reg};
    wire word_ok = take && (wide_mode_out || byte_half_reg || st_reg == PPB_ST_KEY);
    wire [15:0] word = (narrow && st_reg != PPB_ST_KEY) ? pair_word : data_s2_reg;

    always_comb
    begin
        hs_next = hs_reg;
        unique case (hs_reg)
            PPB_HS_READY:
                if (take)
                    hs_next = PPB_HS_RELEASE;
            PPB_HS_RELEASE:
                if (!strobe_low)
                    hs_next = active ? PPB_HS_READY : PPB_HS_IDLE;
            PPB_HS_IDLE:
                hs_next = PPB_HS_IDLE;
            default:
                hs_next = PPB_HS_IDLE;
        endcase
    end

    // ************************************************
    // stream parser
    // ************************************************
    logic [3:0] rsv_cnt_reg;
    logic [15:0] left_reg;
    logic [15:0] pc_hi_reg;
    logic [15:0] adr_hi_reg;
    wire key_wide = data_s2_reg == PPB_KEY_WIDE;
    wire key_narrow_lo = pin_byte == PPB_KEY_NARROW_LO;
    wire key_narrow = {pin_byte, low_byte_reg} == PPB_KEY_NARROW;

    always_comb
    begin
        st_next = st_reg;
        if (take)
        begin
            unique case (st_reg)
                PPB_ST_KEY:
                    if (key_wide)
                        st_next = PPB_ST_RSV;
                    else if (key_narrow_lo)
                        st_next = PPB_ST_KEY_HI;
                    else
                        st_next = PPB_ST_ERR;
                PPB_ST_KEY_HI:
                    st_next = key_narrow ? PPB_ST_RSV : PPB_ST_ERR;
                PPB_ST_RSV:
                    if (word_ok && rsv_cnt_reg == PPB_RSV_ONE)
                        st_next = PPB_ST_PC_HI;
                PPB_ST_PC_HI:
                    if (word_ok)
                        st_next = PPB_ST_PC_LO;
                PPB_ST_PC_LO:
                    if (word_ok)
                        st_next = PPB_ST_SIZE;
                PPB_ST_SIZE:
                    if (word_ok)
                        st_next = (word == PPB_END_SIZE) ? PPB_ST_DONE : PPB_ST_ADR_HI;
                PPB_ST_ADR_HI:
                    if (word_ok)
                        st_next = PPB_ST_ADR_LO;
                PPB_ST_ADR_LO:
                    if (word_ok)
                        st_next = PPB_ST_DATA;
                PPB_ST_DATA:
                    if (word_ok && left_reg == PPB_ONE16)
                        st_next = PPB_ST_SIZE;
                PPB_ST_DONE,
                PPB_ST_ERR:
                    st_next = st_reg;
                default:
                    st_next = PPB_ST_ERR;
            endcase
        end
    end

    // ************************************************
    // registers
    // ************************************************
    // no timeouts anywhere, pure wait
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            hs_reg <= PPB_HS_READY;
            st_reg <= PPB_ST_KEY;
            ready_n_reg <= 1'b1;
            byte_half_reg <= 1'b0;
            low_byte_reg <= 8'h00;
            rsv_cnt_reg <= PPB_RSV_WORDS;
            left_reg <= PPB_ZERO16;
            pc_hi_reg <= PPB_ZERO16;
            adr_hi_reg <= PPB_ZERO16;
            wr_valid_out <= 1'b0;
            wr_addr_out <= PPB_ZERO32;
            wr_data_out <= PPB_ZERO16;
            entry_point_out <= PPB_ZERO32;
            wide_mode_out <= 1'b0;
            done_out <= 1'b0;
            error_out <= 1'b0;
        end
        else
        begin
            hs_reg <= hs_next;
            st_reg <= st_next;
            ready_n_reg <= !(hs_next == PPB_HS_READY);
            wr_valid_out <= 1'b0;
            done_out <= st_next == PPB_ST_DONE;
            error_out <= st_next == PPB_ST_ERR;
            if (take)
            begin
                if (st_reg == PPB_ST_KEY)
                begin
                    wide_mode_out <= key_wide;
                    low_byte_reg <= pin_byte;
                    byte_half_reg <= 1'b0;
                end
                // second key byte closes its pair; data pairing starts clean
                else if (narrow && !byte_half_reg && st_reg != PPB_ST_KEY_HI)
                begin
                    low_byte_reg <= pin_byte;
                    byte_half_reg <= 1'b1;
                end
                else
                    byte_half_reg <= 1'b0;
            end
            if (word_ok)
            begin
                if (st_reg == PPB_ST_RSV)
                    rsv_cnt_reg <= rsv_cnt_reg - PPB_RSV_ONE;
                if (st_reg == PPB_ST_PC_HI)
                    pc_hi_reg <= word;
                if (st_reg == PPB_ST_PC_LO)
                    entry_point_out <= {pc_hi_reg, word};
                if (st_reg == PPB_ST_SIZE)
                    left_reg <= word;
                if (st_reg == PPB_ST_ADR_HI)
                    adr_hi_reg <= word;
                if (st_reg == PPB_ST_ADR_LO)
                    wr_addr_out <= {adr_hi_reg, word} - PPB_ONE32;
                if (st_reg == PPB_ST_DATA)
                begin
                    wr_valid_out <= 1'b1;
                    wr_data_out <= word;
                    wr_addr_out <= wr_addr_out + PPB_ONE32;
                    left_reg <= left_reg - PPB_ONE16;
                end
            end
        end
    end

    assign link.device_ready_line_n = ready_n_reg;
endmodule : ppb_receiver
`default_nettype wire

/* verilog/ppb_pkg.sv */
// shared constants for the parallel pin boot link
`default_nettype none
package ppb_pkg;
    localparam int PPB_DW = 16;
    localparam int PPB_AW = 32;
    localparam logic [15:0] PPB_KEY_WIDE = 16'h10AA;
    localparam logic [15:0] PPB_KEY_NARROW = 16'h08AA;
    localparam logic [7:0] PPB_KEY_NARROW_LO = 8'hAA;
    localparam logic [15:0] PPB_END_SIZE = 16'h0000;
    localparam logic [3:0] PPB_RSV_WORDS = 4'h8;
    localparam logic [3:0] PPB_RSV_ONE = 4'h1;
    localparam logic [15:0] PPB_ONE16 = 16'h0001;
    localparam logic [31:0] PPB_ONE32 = 32'h00000001;
    localparam logic [31:0] PPB_ZERO32 = 32'h00000000;
    localparam logic [15:0] PPB_ZERO16 = 16'h0000;
    localparam logic [1:0] PPB_SYNC_RST = 2'h3;
endpackage : ppb_pkg
`default_nettype wire

/* verilog/ppb_link_if.sv */
// pin bundle between the boot receiver and the host sender
`timescale 1ns/1ns
`default_nettype none
interface ppb_link_if;
    logic [15:0] data_pins;
    logic device_ready_line_n;
    logic host_strobe_line_n;
    modport device_end
    (
        input data_pins,
        input host_strobe_line_n,
        output device_ready_line_n
    );
    modport host_end
    (
        output data_pins,
        output host_strobe_line_n,
        input device_ready_line_n
    );
endinterface : ppb_link_if
`default_nettype wire

/* verilog/ppb_sender.sv */
// host end: pushes stream words over the pin handshake
`timescale 1ns/1ns
`default_nettype none
module ppb_sender
    import ppb_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // user side word source
    input wire logic word_valid_in,
    input wire logic [15:0] word_in,
    input wire logic byte_mode_in,
    output logic word_ready_out,
    // link pins
    ppb_link_if.host_end link
);
    // ************************************************
    // states
    // ************************************************
    typedef enum logic [1:0]
    {
        PPB_TX_IDLE = 2'b00,
        PPB_TX_SETUP = 2'b01,
        PPB_TX_STROBE = 2'b10,
        PPB_TX_RELEASE = 2'b11
    } ppb_tx_type;

    logic [1:0] ready_sync_reg;
    ppb_tx_type tx_reg, tx_next;
    logic [15:0] hold_reg;
    logic [15:0] pins_reg;
    logic strobe_n_reg;
    logic second_reg;
    wire dev_ready = ~ready_sync_reg[1];
    wire last_part = !byte_mode_in || second_reg;

    always_comb
    begin
        tx_next = tx_reg;
        unique case (tx_reg)
            PPB_TX_IDLE:
                if (word_valid_in)
                    tx_next = PPB_TX_SETUP;
            // data set one cycle before strobe
            PPB_TX_SETUP:
                if (dev_ready)
                    tx_next = PPB_TX_STROBE;
            PPB_TX_STROBE:
                if (!dev_ready)
                    tx_next = PPB_TX_RELEASE;
            PPB_TX_RELEASE:
                tx_next = last_part ? PPB_TX_IDLE : PPB_TX_SETUP;
        endcase
    end

    // ************************************************
    // registers
    // ************************************************
    // waits on the device, any speed
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            ready_sync_reg <= PPB_SYNC_RST;
            tx_reg <= PPB_TX_IDLE;
            hold_reg <= PPB_ZERO16;
            pins_reg <= PPB_ZERO16;
            strobe_n_reg <= 1'b1;
            second_reg <= 1'b0;
            word_ready_out <= 1'b0;
        end
        else
        begin
            ready_sync_reg <= {ready_sync_reg[0], link.device_ready_line_n};
            tx_reg <= tx_next;
            strobe_n_reg <= !(tx_next == PPB_TX_STROBE);
            word_ready_out <= (tx_reg == PPB_TX_RELEASE) && last_part;
            if (tx_reg == PPB_TX_IDLE && word_valid_in)
            begin
                hold_reg <= word_in;
                second_reg <= 1'b0;
                // low byte goes first
                // upper pins carry the other byte; the device must mask them
                pins_reg <= word_in;
            end
            if (tx_reg == PPB_TX_RELEASE && !last_part)
            begin
                second_reg <= 1'b1;
                pins_reg <= {hold_reg[7:0], hold_reg[15:8]};
            end
        end
    end

    assign link.data_pins = pins_reg;
    assign link.host_strobe_line_n = strobe_n_reg;
endmodule : ppb_sender
`default_nettype wire

/* bench/ppb_link_assertions.sv */
// handshake checker watching the boot link pins
`timescale 1ns/1ns
`default_nettype none
module ppb_link_assertions
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // link pins
    input wire logic [15:0] data_pins,
    input wire logic device_ready_line_n,
    input wire logic host_strobe_line_n
);
    // ****
    // handshake checks
    // ****
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_strobe_fall;
        $fell(host_strobe_line_n);
    endsequence
    sequence s_read_done;
        $rose(device_ready_line_n) ##0 !host_strobe_line_n;
    endsequence

    a_strobe_needs_ready: assert property (s_strobe_fall |-> !device_ready_line_n)
        else $error("strobe fell while ready was high");
    a_data_setup: assert property (s_strobe_fall |-> $stable(data_pins))
        else $error("data changed with the strobe edge");
    a_data_hold: assert property ((!host_strobe_line_n && !$past(host_strobe_line_n))
        |-> $stable(data_pins))
        else $error("data changed while strobe low");
    a_ready_answers: assert property (s_strobe_fall |-> ##[1:4] device_ready_line_n)
        else $error("ready not raised after strobe");
    a_ready_waits: assert property ($fell(device_ready_line_n)
        |-> $past(host_strobe_line_n))
        else $error("ready lowered before strobe release");
    a_ready_holds_high: assert property ((device_ready_line_n && !host_strobe_line_n)
        |=> device_ready_line_n)
        else $error("ready dropped while strobe low");
    a_ready_holds_low: assert property ((!device_ready_line_n && host_strobe_line_n)
        |=> !device_ready_line_n)
        else $error("ready withdrawn without a transfer");
    a_strobe_released: assert property (s_read_done |-> ##[1:8] host_strobe_line_n)
        else $error("strobe not released after ready");
    a_strobe_holds: assert property ((!host_strobe_line_n && !device_ready_line_n)
        |=> !host_strobe_line_n)
        else $error("strobe released before the read");
endmodule // ppb_link_assertions
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench joining sender and receiver over the pins
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import ppb_pkg::*;
    // ****
    // signals and instances
    // ****
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic word_valid_in = 1'b0;
    logic [15:0] word_in = 16'h0000;
    logic byte_mode_in = 1'b0;
    logic word_ready_out, wr_valid_out, wide_mode_out, done_out, error_out;
    logic [31:0] wr_addr_out, entry_point_out;
    logic [15:0] wr_data_out;
    logic strobe_seen = 1'b1;
    logic [15:0] stream[$], exp_data[$], got_data[$], pin_log[$];
    logic [31:0] exp_addr[$], got_addr[$];
    int n_fail = 0;
    int samples_checked = 0;
    ppb_link_if link ();
    ppb_sender ppb_sender_i (.clk_in(clk_in), .rst_in(rst_in), .word_valid_in(word_valid_in),
        .word_in(word_in), .byte_mode_in(byte_mode_in), .word_ready_out(word_ready_out),
        .link(link));
    ppb_receiver ppb_receiver_i (.clk_in(clk_in), .rst_in(rst_in), .link(link),
        .wr_valid_out(wr_valid_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out),
        .entry_point_out(entry_point_out), .wide_mode_out(wide_mode_out),
        .done_out(done_out), .error_out(error_out));
    ppb_link_assertions ppb_link_assertions_i (.clk_in(clk_in), .rst_in(rst_in),
        .data_pins(link.data_pins), .device_ready_line_n(link.device_ready_line_n),
        .host_strobe_line_n(link.host_strobe_line_n));
    always #10 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        strobe_seen <= link.host_strobe_line_n;
        if (strobe_seen === 1'b1 && link.host_strobe_line_n === 1'b0)
            pin_log.push_back(link.data_pins);
        if (wr_valid_out === 1'b1)
        begin
            got_addr.push_back(wr_addr_out);
            got_data.push_back(wr_data_out);
        end
    end
    // ****
    // tasks
    // ****
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic restart();
        @(posedge clk_in);
        #1 rst_in = 1'b1;
        repeat (3) @(posedge clk_in);
        #1 rst_in = 1'b0;
        got_addr = {};
        got_data = {};
        pin_log = {};
    endtask
    task automatic send_word(input logic [15:0] w, output bit ok);
        ok = 1'b0;
        @(posedge clk_in);
        #1 word_valid_in = 1'b1;
        word_in = w;
        for (int i = 0; i < 200 && !ok; i++)
        begin
            @(posedge clk_in);
            #1 ok = (word_ready_out === 1'b1);
        end
        word_valid_in = 1'b0;
    endtask
    task automatic head(input logic [15:0] key, input logic [31:0] pc);
        stream = {key};
        repeat (8) stream.push_back(PPB_ZERO16);
        stream.push_back(pc[31:16]);
        stream.push_back(pc[15:0]);
        exp_addr = {};
        exp_data = {};
    endtask
    task automatic block(input logic [15:0] n, input logic [31:0] a, input logic [15:0] d);
        stream.push_back(n);
        stream.push_back(a[31:16]);
        stream.push_back(a[15:0]);
        for (int i = 0; i < n; i++)
        begin
            stream.push_back(d + i[15:0]);
            exp_data.push_back(d + i[15:0]);
            exp_addr.push_back(a + i[31:0]);
        end
    endtask
    // slow host: gap idles the user side between words
    task automatic send_all(input logic bm, input int gap);
        bit ok;
        byte_mode_in = bm;
        stream.push_back(PPB_END_SIZE);
        foreach (stream[k])
        begin
            send_word(stream[k], ok);
            check("word accepted", 32'h1, {31'h0, ok});
            repeat (gap) @(posedge clk_in);
        end
    endtask
    task automatic judge(input logic wide, input logic [31:0] pc);
        for (int i = 0; i < 20 && done_out !== 1'b1; i++)
            @(posedge clk_in);
        check("done", 32'h1, {31'h0, done_out});
        check("error", 32'h0, {31'h0, error_out});
        check("wide mode", {31'h0, wide}, {31'h0, wide_mode_out});
        check("entry point", pc, entry_point_out);
        check("strobes", 32'(stream.size() * (wide ? 1 : 2)), 32'(pin_log.size()));
        check("writes", 32'(exp_addr.size()), 32'(got_addr.size()));
        foreach (exp_addr[k])
        begin
            check("write addr", exp_addr[k], got_addr[k]);
            check("write data", {16'h0, exp_data[k]}, {16'h0, got_data[k]});
        end
        check("ready after done", 32'h1, {31'h0, link.device_ready_line_n});
    endtask
    task automatic test_wide();
        restart();
        head(PPB_KEY_WIDE, 32'h0012_3456);
        block(16'h0003, 32'h0000_8000, 16'hA5A0);
        block(16'h0002, 32'h0001_FFFF, 16'h5A5F);
        send_all(1'b0, 0);
        judge(1'b1, 32'h0012_3456);
        check("wide key pins", {16'h0, PPB_KEY_WIDE}, {16'h0, pin_log[0]});
        $display("test wide stream finished");
    endtask
    task automatic test_byte();
        restart();
        head(PPB_KEY_NARROW, 32'h0055_AA01);
        block(16'h0002, 32'h1234_0000, 16'hFE01);
        block(16'h0001, 32'h0000_FFFE, 16'h80FF);
        send_all(1'b1, 3);
        judge(1'b0, 32'h0055_AA01);
        check("first byte", 32'hAA, {24'h0, pin_log[0][7:0]});
        check("second byte", 32'h08, {24'h0, pin_log[1][7:0]});
        $display("test byte stream finished");
    endtask
    task automatic test_bad_key();
        bit ok;
        restart();
        byte_mode_in = 1'b0;
        send_word(16'h1234, ok);
        check("bad key sent", 32'h1, {31'h0, ok});
        for (int i = 0; i < 20 && error_out !== 1'b1; i++)
            @(posedge clk_in);
        check("error", 32'h1, {31'h0, error_out});
        check("done", 32'h0, {31'h0, done_out});
        send_word(PPB_KEY_WIDE, ok);
        check("word refused", 32'h0, {31'h0, ok});
        check("writes", 32'h0, 32'(got_addr.size()));
        $display("test bad key finished");
    endtask
    // low key byte right, high key byte wrong
    task automatic test_bad_pair();
        bit ok;
        restart();
        byte_mode_in = 1'b1;
        send_word(16'h07AA, ok);
        check("bad pair sent", 32'h1, {31'h0, ok});
        for (int i = 0; i < 20 && error_out !== 1'b1; i++)
            @(posedge clk_in);
        check("pair error", 32'h1, {31'h0, error_out});
        check("pair wide mode", 32'h0, {31'h0, wide_mode_out});
        check("pair strobes", 32'h2, 32'(pin_log.size()));
        check("pair writes", 32'h0, 32'(got_addr.size()));
        $display("test bad byte pair finished");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ****
    // run
    // ****
    initial
    begin
        test_wide();
        test_byte();
        test_bad_pair();
        test_bad_key();
        complete_run();
    end
    // tests need little over a thousand cycles; twenty times that means a hang
    initial
    begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        complete_run();
    end
endmodule // testbench
`default_nettype wire
